//--- hpfs_pkg.sv
// Package for the host port pin function select block
package hpfs_pkg;
    // Control word bit positions
    localparam int CTL_WIDTH      = 16;
    localparam int BIT_HOST_EN    = 0;
    localparam int BIT_MUX_BUS    = 1;
    localparam int BIT_DBL_STROBE = 2;
    localparam int BIT_DBL_REQ    = 3;
    localparam int BIT_REQ_OD     = 4;
    localparam int BIT_CS_POL     = 5;
    localparam int BIT_DS_POL     = 6;
    localparam int BIT_REQ_POL    = 7;
    localparam int BIT_ACK_POL    = 8;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [5:0]  DIR_RESET = 6'h00;
    localparam logic [5:0]  OUT_RESET = 6'h00;
    localparam int NPIN           = 6;
    // Pin indices within the upper group
    localparam int PIN_A2  = 0;
    localparam int PIN_RW  = 1;
    localparam int PIN_DS  = 2;
    localparam int PIN_CS  = 3;
    localparam int PIN_REQ = 4;
    localparam int PIN_ACK = 5;

    typedef struct packed {
        logic addr_in_two;
        logic mux_addr_nine;
        logic mux_addr_ten;
        logic chip_select_in;
        logic read_write_select;
        logic data_strobe;
        logic read_strobe;
        logic write_strobe;
        logic acknowledge_in;
    } hpfs_host_in_t;

    typedef struct packed {
        logic combined_request_out;
        logic transmit_request_out;
        logic receive_request_out;
    } hpfs_req_t;

    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  s3;
        logic [5:0]  filt;
        logic [15:0] ctl;
        logic [5:0]  dir;
        logic [5:0]  pin_out;
        logic [5:0]  pin_oe;
        logic [5:0]  gp_in;
        hpfs_host_in_t host;
        logic        stopped;
    } hpfs_state_t;
endpackage

//--- hpfs_pin_select.sv
// Upper host-port pin function select and GPIO
module hpfs_pin_select (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   ctl_wr_i,
    input  wire logic [15:0]            ctl_data_i,
    input  wire logic                   dir_wr_i,
    input  wire logic [5:0]             dir_data_i,
    input  wire logic [5:0]             gp_out_i,
    input  wire logic                   stop_i,
    input  wire logic                   wait_i,
    input  wire hpfs_pkg::hpfs_req_t    req_i,
    input  wire logic [5:0]             pin_i,
    output logic [5:0]                  pin_o,
    output logic [5:0]                  pin_oe_o,
    output hpfs_pkg::hpfs_host_in_t     host_o,
    output logic [5:0]                  gp_in_o,
    output logic [15:0]                 ctl_o,
    output logic [5:0]                  dir_o
);
    hpfs_pkg::hpfs_state_t st;
    hpfs_pkg::hpfs_state_t next_st;

    // Polarity fold: a set bit means active high at the pin
    function automatic logic pol(input logic v, input logic hi);
        pol = hi ? v : ~v;
    endfunction

    // Pin level and enable for a request, open drain only pulls to the low level, whichever polarity is set
    function automatic logic [1:0] req_drive(input logic act, input logic hi, input logic od);
        logic lvl;
        lvl = hi ? act : ~act;
        if (od)
            req_drive = {1'b0, ~lvl};
        else
            req_drive = {lvl, 1'b1};
    endfunction

    // Settle filter: a bit follows the pins only once two stages agree, so one glitch never reaches the host
    function automatic logic [5:0] settle(input logic [5:0] a, input logic [5:0] b, input logic [5:0] held);
        logic [5:0] same;
        same = a ~^ b;
        settle = (same & b) | (~same & held);
    endfunction

    logic host_en;
    logic mux_bus;
    logic dbl_strobe;
    logic dbl_req;
    logic [5:0] pin_sync;
    logic [1:0] rq_a;
    logic [1:0] rq_b;
    assign host_en    = st.ctl[hpfs_pkg::BIT_HOST_EN];
    assign mux_bus    = st.ctl[hpfs_pkg::BIT_MUX_BUS];
    assign dbl_strobe = st.ctl[hpfs_pkg::BIT_DBL_STROBE];
    assign dbl_req    = st.ctl[hpfs_pkg::BIT_DBL_REQ];

    always_comb
    begin
        next_st = st;
        pin_sync = 6'h00;
        rq_a = 2'h0;
        rq_b = 2'h0;
        // Three stages; change counts when second and third agree
        next_st.s1   = pin_i;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        pin_sync     = settle(st.s2, st.s3, st.filt);
        next_st.filt = pin_sync;
        next_st.stopped = stop_i;
        // Wait has no effect on anything below
        if (ctl_wr_i && !stop_i)
            next_st.ctl = ctl_data_i;
        if (dir_wr_i && !stop_i)
            next_st.dir = dir_data_i;
        if (!stop_i)
        begin
            next_st.gp_in = pin_sync;
            next_st.host = '0;
            if (host_en)
            begin
                next_st.host.addr_in_two   = !mux_bus && pin_sync[hpfs_pkg::PIN_A2];
                next_st.host.mux_addr_nine = mux_bus && pin_sync[hpfs_pkg::PIN_A2];
                next_st.host.chip_select_in = !mux_bus
                    && pol(pin_sync[hpfs_pkg::PIN_CS], st.ctl[hpfs_pkg::BIT_CS_POL]);
                next_st.host.mux_addr_ten  = mux_bus && pin_sync[hpfs_pkg::PIN_CS];
                next_st.host.read_write_select = !dbl_strobe && pin_sync[hpfs_pkg::PIN_RW];
                next_st.host.data_strobe = !dbl_strobe
                    && pol(pin_sync[hpfs_pkg::PIN_DS], st.ctl[hpfs_pkg::BIT_DS_POL]);
                next_st.host.read_strobe = dbl_strobe
                    && pol(pin_sync[hpfs_pkg::PIN_RW], st.ctl[hpfs_pkg::BIT_DS_POL]);
                next_st.host.write_strobe = dbl_strobe
                    && pol(pin_sync[hpfs_pkg::PIN_DS], st.ctl[hpfs_pkg::BIT_DS_POL]);
                next_st.host.acknowledge_in = !dbl_req
                    && pol(pin_sync[hpfs_pkg::PIN_ACK], st.ctl[hpfs_pkg::BIT_ACK_POL]);
            end
        end
        // Output drivers
        next_st.pin_oe = 6'h00;
        next_st.pin_out = 6'h00;
        if (host_en)
        begin
            rq_a = req_drive(dbl_req ? req_i.transmit_request_out : req_i.combined_request_out,
                             st.ctl[hpfs_pkg::BIT_REQ_POL], st.ctl[hpfs_pkg::BIT_REQ_OD]);
            rq_b = req_drive(req_i.receive_request_out,
                             st.ctl[hpfs_pkg::BIT_REQ_POL], st.ctl[hpfs_pkg::BIT_REQ_OD]);
            next_st.pin_out[hpfs_pkg::PIN_REQ] = rq_a[1];
            next_st.pin_oe[hpfs_pkg::PIN_REQ]  = rq_a[0];
            if (dbl_req)
            begin
                next_st.pin_out[hpfs_pkg::PIN_ACK] = rq_b[1];
                next_st.pin_oe[hpfs_pkg::PIN_ACK]  = rq_b[0];
            end
        end
        else
        begin
            next_st.pin_out = gp_out_i;
            next_st.pin_oe  = next_st.dir;
        end
        if (stop_i)
            next_st.pin_oe = 6'h00;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
            st.ctl <= hpfs_pkg::CTL_RESET;
            st.dir <= hpfs_pkg::DIR_RESET;
            st.pin_out <= hpfs_pkg::OUT_RESET;
        end
        else
            st <= next_st;
    end

    assign pin_o    = st.pin_out;
    assign pin_oe_o = st.pin_oe;
    assign host_o   = st.host;
    assign gp_in_o  = st.gp_in;
    assign ctl_o    = st.ctl;
    assign dir_o    = st.dir;

    property p_stop_tristate;
        @(posedge sys_clk_i) disable iff (!rst_b_i) stop_i |=> (pin_oe_o == 6'h00);
    endproperty
    a_stop_tristate: assert property (p_stop_tristate) else $error("Pins driven in stop");

    property p_stop_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i) stop_i |=> $stable(host_o) && $stable(ctl_o);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("State changed in stop");

    property p_gpio_dir;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (!ctl_o[hpfs_pkg::BIT_HOST_EN] && !stop_i && !ctl_wr_i && !dir_wr_i) |=> (pin_oe_o == $past(dir_o));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("GPIO direction wrong");

    property p_ctl_load;
        @(posedge sys_clk_i) disable iff (!rst_b_i) (ctl_wr_i && !stop_i) |=> ctl_o == $past(ctl_data_i);
    endproperty
    a_ctl_load: assert property (p_ctl_load) else $error("Control not loaded");

    property p_mux_a9;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && mux_bus && !stop_i && !ctl_wr_i)
            |=> host_o.mux_addr_nine == $past(pin_sync[hpfs_pkg::PIN_A2]) && !host_o.addr_in_two;
    endproperty
    a_mux_a9: assert property (p_mux_a9) else $error("Address nine wrong");

    property p_a2;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !mux_bus && !stop_i) |=> host_o.addr_in_two == $past(pin_sync[hpfs_pkg::PIN_A2]);
    endproperty
    a_a2: assert property (p_a2) else $error("Address two wrong");

    property p_cs_pol;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !mux_bus && !stop_i)
            |=> host_o.chip_select_in == ($past(pin_sync[hpfs_pkg::PIN_CS]) ~^ $past(st.ctl[hpfs_pkg::BIT_CS_POL]));
    endproperty
    a_cs_pol: assert property (p_cs_pol) else $error("Chip select polarity wrong");

    property p_req_od;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && st.ctl[hpfs_pkg::BIT_REQ_OD] && !stop_i) |=> pin_o[4] == 1'b0;
    endproperty
    a_req_od: assert property (p_req_od) else $error("Open drain drove high");

    property p_wait;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (wait_i && !stop_i && !ctl_wr_i && !dir_wr_i && $stable(pin_i) && $stable(req_i) && $stable(gp_out_i))
            ##1 (wait_i && $stable(pin_i) && $stable(req_i) && $stable(gp_out_i) && !stop_i && !ctl_wr_i && !dir_wr_i)
            |=> $stable(pin_oe_o);
    endproperty
    a_wait: assert property (p_wait) else $error("Wait changed pins");

    // Reset leaves GPIO mode, active-low polarities and all pins undriven
    property p_reset_state;
        @(posedge sys_clk_i)
            !rst_b_i
            |=> ctl_o == hpfs_pkg::CTL_RESET && pin_oe_o == 6'h00 && host_o == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("Reset state wrong");

    property p_stopped_quiet;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            st.stopped
            |-> pin_oe_o == 6'h00;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet) else $error("Pins driven while stopped");

    property p_stop_refuse_dir;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (stop_i && dir_wr_i)
            |=> $stable(dir_o);
    endproperty
    a_stop_refuse_dir: assert property (p_stop_refuse_dir) else $error("Direction written in stop");

    property p_gp_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            stop_i
            |=> $stable(gp_in_o);
    endproperty
    a_gp_hold: assert property (p_gp_hold) else $error("Port inputs changed in stop");

    property p_dir_load;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (dir_wr_i && !stop_i)
            |=> dir_o == $past(dir_data_i);
    endproperty
    a_dir_load: assert property (p_dir_load) else $error("Direction not loaded");

    property p_gp_in;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            !stop_i
            |=> gp_in_o == $past(pin_sync);
    endproperty
    a_gp_in: assert property (p_gp_in) else $error("Port input sample wrong");

    property p_gp_host_zero;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (!host_en && !stop_i)
            |=> host_o == '0;
    endproperty
    a_gp_host_zero: assert property (p_gp_host_zero) else $error("Host inputs live in GPIO mode");

    property p_mux_a10;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && mux_bus && !stop_i)
            |=> host_o.mux_addr_ten == $past(pin_sync[hpfs_pkg::PIN_CS]) && !host_o.chip_select_in;
    endproperty
    a_mux_a10: assert property (p_mux_a10) else $error("Address ten wrong");

    property p_rw_dir;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !dbl_strobe && !stop_i)
            |=> host_o.read_write_select == $past(pin_sync[hpfs_pkg::PIN_RW]) && !host_o.read_strobe;
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("Read/write select wrong");

    property p_ds;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !dbl_strobe && !stop_i)
            |=> host_o.data_strobe == ($past(pin_sync[hpfs_pkg::PIN_DS]) ~^ $past(st.ctl[hpfs_pkg::BIT_DS_POL]));
    endproperty
    a_ds: assert property (p_ds) else $error("Data strobe wrong");

    property p_rd;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && dbl_strobe && !stop_i)
            |=> host_o.read_strobe == ($past(pin_sync[hpfs_pkg::PIN_RW]) ~^ $past(st.ctl[hpfs_pkg::BIT_DS_POL]));
    endproperty
    a_rd: assert property (p_rd) else $error("Read strobe wrong");

    property p_wr;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && dbl_strobe && !stop_i)
            |=> host_o.write_strobe == ($past(pin_sync[hpfs_pkg::PIN_DS]) ~^ $past(st.ctl[hpfs_pkg::BIT_DS_POL]));
    endproperty
    a_wr: assert property (p_wr) else $error("Write strobe wrong");

    property p_strobe_quiet;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && dbl_strobe && !stop_i)
            |=> !host_o.read_write_select && !host_o.data_strobe;
    endproperty
    a_strobe_quiet: assert property (p_strobe_quiet) else $error("Single strobe live in double mode");

    property p_ack;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !dbl_req && !stop_i)
            |=> host_o.acknowledge_in == ($past(pin_sync[hpfs_pkg::PIN_ACK]) ~^ $past(st.ctl[hpfs_pkg::BIT_ACK_POL]));
    endproperty
    a_ack: assert property (p_ack) else $error("Acknowledge wrong");

    property p_ack_quiet;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && dbl_req && !stop_i)
            |=> !host_o.acknowledge_in;
    endproperty
    a_ack_quiet: assert property (p_ack_quiet) else $error("Acknowledge live in double request");

    property p_req_single;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !dbl_req && !st.ctl[hpfs_pkg::BIT_REQ_OD] && !stop_i)
            |=> pin_oe_o[4] && pin_o[4] == ($past(req_i.combined_request_out) ~^ $past(st.ctl[hpfs_pkg::BIT_REQ_POL]));
    endproperty
    a_req_single: assert property (p_req_single) else $error("Combined request wrong");

    property p_req_tx;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && dbl_req && !st.ctl[hpfs_pkg::BIT_REQ_OD] && !stop_i)
            |=> pin_oe_o[4] && pin_o[4] == ($past(req_i.transmit_request_out) ~^ $past(st.ctl[hpfs_pkg::BIT_REQ_POL]));
    endproperty
    a_req_tx: assert property (p_req_tx) else $error("Transmit request wrong");

    property p_req_rx;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && dbl_req && !st.ctl[hpfs_pkg::BIT_REQ_OD] && !stop_i)
            |=> pin_oe_o[5] && pin_o[5] == ($past(req_i.receive_request_out) ~^ $past(st.ctl[hpfs_pkg::BIT_REQ_POL]));
    endproperty
    a_req_rx: assert property (p_req_rx) else $error("Receive request wrong");

    // Open drain only sinks: enable while the request is at its low level
    property p_od_enable;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && st.ctl[hpfs_pkg::BIT_REQ_OD] && !stop_i)
            |=> pin_oe_o[4] == !($past(dbl_req ? req_i.transmit_request_out : req_i.combined_request_out)
                ~^ $past(st.ctl[hpfs_pkg::BIT_REQ_POL]));
    endproperty
    a_od_enable: assert property (p_od_enable) else $error("Open drain enable wrong");

    property p_pol_fold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (host_en && !mux_bus && !stop_i && pin_sync[hpfs_pkg::PIN_CS] == st.ctl[hpfs_pkg::BIT_CS_POL])
            |=> host_o.chip_select_in;
    endproperty
    a_pol_fold: assert property (p_pol_fold) else $error("Polarity fold wrong");
endmodule // hpfs_pin_select

//--- hpfs_host_model.sv
// Host-side model that resolves the upper host-port pin levels
module hpfs_host_model (
    input  wire logic [5:0] pin_o_i,
    input  wire logic [5:0] pin_oe_i,
    input  wire logic [5:0] drv_i,
    input  wire logic [5:0] drv_en_i,
    output logic [5:0]      pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up on undriven lines, needed by open-drain requests
    assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_en_i & drv_i)
                     | (~pin_oe_i & ~drv_en_i);
endmodule // hpfs_host_model

//--- tb_hpfs_pin_select.sv
// Testbench for the host port pin function select block
module tb_hpfs_pin_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ctl_wr_i = 1'b0;
    logic [15:0] ctl_data_i = 16'h0000;
    logic dir_wr_i = 1'b0;
    logic [5:0] dir_data_i = 6'h00;
    logic [5:0] gp_out_i = 6'h00;
    logic stop_i = 1'b0;
    logic wait_i = 1'b0;
    logic [5:0] drv = 6'h00;
    logic [5:0] drv_en = 6'h3f;
    hpfs_pkg::hpfs_req_t req_i = '0;
    hpfs_pkg::hpfs_host_in_t host_o;
    logic [5:0] pin_i, pin_o, pin_oe_o, gp_in_o, dir_o, eo, lv;
    logic [15:0] ctl_o, c;
    int err_total = 0;
    int total_checks = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    hpfs_pin_select i_hpfs_pin_select (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ctl_wr_i(ctl_wr_i),
        .ctl_data_i(ctl_data_i), .dir_wr_i(dir_wr_i), .dir_data_i(dir_data_i), .gp_out_i(gp_out_i),
        .stop_i(stop_i), .wait_i(wait_i), .req_i(req_i), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .host_o(host_o), .gp_in_o(gp_in_o), .ctl_o(ctl_o), .dir_o(dir_o));
    hpfs_host_model i_hpfs_host_model (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .drv_i(drv),
        .drv_en_i(drv_en), .pin_lvl_o(pin_i));

    task automatic chk_w(logic [15:0] got, logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_h(hpfs_pkg::hpfs_host_in_t got, hpfs_pkg::hpfs_host_in_t exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t host inputs %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr_ctl(logic [15:0] d);
        @(negedge sys_clk_i) ctl_wr_i = 1'b1;
        ctl_data_i = d;
        @(negedge sys_clk_i) ctl_wr_i = 1'b0;
    endtask

    task automatic wr_dir(logic [5:0] d);
        @(negedge sys_clk_i) dir_wr_i = 1'b1;
        dir_data_i = d;
        @(negedge sys_clk_i) dir_wr_i = 1'b0;
    endtask

    // Decoded view of the pins, active high after polarity
    function automatic hpfs_pkg::hpfs_host_in_t exp_host(logic [15:0] w, logic [5:0] p);
        hpfs_pkg::hpfs_host_in_t h;
        h = '0;
        h.mux_addr_nine = w[1] & p[0];
        h.mux_addr_ten = w[1] & p[3];
        h.addr_in_two = ~w[1] & p[0];
        h.chip_select_in = ~w[1] & (p[3] ~^ w[5]);
        h.read_strobe = w[2] & (p[1] ~^ w[6]);
        h.write_strobe = w[2] & (p[2] ~^ w[6]);
        h.read_write_select = ~w[2] & p[1];
        h.data_strobe = ~w[2] & (p[2] ~^ w[6]);
        h.acknowledge_in = ~w[3] & (p[5] ~^ w[8]);
        return w[0] ? h : '0;
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (1000) @(posedge sys_clk_i);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end

    initial
    begin
        repeat (10) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        @(negedge sys_clk_i);
        chk_w(ctl_o, hpfs_pkg::CTL_RESET);
        chk_w({10'h000, pin_oe_o}, 16'h0000);
        chk_h(host_o, '0);
        drv = 6'h0a;
        drv_en = 6'h2a;
        gp_out_i = 6'h3f;
        wr_dir(6'h15);
        repeat (3) @(negedge sys_clk_i);
        chk_w({10'h000, dir_o}, 16'h0015);
        chk_w({10'h000, pin_oe_o}, 16'h0015);
        chk_w({10'h000, pin_o & pin_oe_o}, 16'h0015);
        chk_w({10'h000, gp_in_o}, 16'h001f);
        // Every bus, strobe, request and drive mode, both polarities
        for (int k = 0; k < 32; k++)
        begin
            c = {7'h00, {4{k[4]}}, k[3:0], 1'b1};
            drv = 6'(k * 7 + 3);
            drv_en = c[3] ? 6'h0f : 6'h2f;
            req_i = 3'(k) ^ 3'b101;
            wait_i = k[1];
            wr_ctl(c);
            repeat (6) @(negedge sys_clk_i);
            lv = {req_i.receive_request_out ~^ c[7], (c[3] ? req_i.transmit_request_out
                 : req_i.combined_request_out) ~^ c[7], 4'h0};
            eo = {c[3], 1'b1, 4'h0};
            if (c[4])
            begin
                eo = eo & ~lv;
                lv = 6'h00;
            end
            chk_w(ctl_o, c);
            chk_h(host_o, exp_host(c, drv));
            chk_w({10'h000, pin_oe_o}, {10'h000, eo});
            chk_w({10'h000, pin_o & pin_oe_o}, {10'h000, lv & eo});
        end
        stop_i = 1'b1;
        wr_ctl(16'h0000);
        wr_dir(6'h00);
        drv = ~drv;
        repeat (3) @(negedge sys_clk_i);
        chk_w({10'h000, pin_oe_o}, 16'h0000);
        chk_w({10'h000, dir_o}, 16'h0015);
        chk_w(ctl_o, c);
        chk_h(host_o, exp_host(c, ~drv));
        close_out();
    end
endmodule // tb_hpfs_pin_select
